// ===== hafe_receive_interface.sv
// digital side of the line front end: symbol timing, 2b1q former, receive decimator
// assumes symbol clock, sync and control pins come asynchronously from the host dsp,
// and the line/hybrid samples come from a converter model on ref_clk
// Overview of operation
// - loopback high drops line input, keeps hybrid
// - gain pins select 0, 3.25, 6, 9 dB
// - receive word is 14-bit straight offset binary
// - sync lags clock by 0..15 sixteenths
// - sync sets decimator phase and output timing
// - 24x modulator, decimate by 12, two words
// - filter passband tracks half the symbol rate
// - all timing derives from the symbol clock
// - line minus hybrid, unity, then gain stage
// - full 14-bit words at every word rate
// - symbol pins form four-level 2b1q pulses
`timescale 1ns/10ps

// =========================================================
// fifo
module hafe_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign level     = count_reg;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hafe_fifo

// =========================================================
// top
module hafe_receive_interface
  import hafe_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              symbol_clock_in,
  input  wire logic              symbol_data_pos,
  input  wire logic              symbol_data_neg,
  input  wire logic              receive_sync_pulse,
  input  wire logic              gain_select_hi,
  input  wire logic              gain_select_lo,
  input  wire logic              loopback_ctrl,
  input  wire logic [IN_W-1:0]   line_receive_input,
  input  wire logic [IN_W-1:0]   hybrid_receive_input,
  output logic      [WORD_W-1:0] receive_word,
  output logic                   receive_word_phase,
  output logic                   receive_word_strobe,
  output logic                   fifo_in_ready,
  output logic      [2:0]        tx_level,
  output logic                   line_disconnect,
  output logic      [1:0]        gain_code,
  output logic                   mod_tick,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest
);
  localparam int LW = $clog2(FIFO_DEPTH_P);

  // =========================================================
  // pin synchronisers: three flops, change taken when stages 2 and 3 agree
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;
  logic [NPIN-1:0] pin_reg;

  assign pin_raw = {loopback_ctrl, gain_select_hi, gain_select_lo, receive_sync_pulse,
                    symbol_data_neg, symbol_data_pos, symbol_clock_in};

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          s1_reg[i]  <= 1'b0;
          s2_reg[i]  <= 1'b0;
          s3_reg[i]  <= 1'b0;
          pin_reg[i] <= 1'b0;
        end else begin
          s1_reg[i] <= pin_raw[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            pin_reg[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate

  logic sclk_q_reg;
  logic sync_q_reg;
  logic sym_edge;
  logic sync_edge;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_q_reg <= 1'b0;
      sync_q_reg <= 1'b0;
    end else begin
      sclk_q_reg <= pin_reg[0];
      sync_q_reg <= pin_reg[3];
    end
  end

  assign sym_edge  = pin_reg[0] & ~sclk_q_reg;
  // sync may land on any sixteenth after the clock edge; only its own edge matters
  assign sync_edge = pin_reg[3] & ~sync_q_reg;

  // =========================================================
  // symbol period measurement
  logic [15:0] period_cnt_reg;
  logic [15:0] period_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      period_cnt_reg <= 16'h0001;
      period_reg     <= PERIOD_RESET;
    end else if (sym_edge) begin
      period_cnt_reg <= 16'h0001;
      // guard against a period shorter than OSR cycles, which would need more than one tick per cycle
      period_reg     <= (period_cnt_reg < OSR) ? OSR : period_cnt_reg;
    end else if (period_cnt_reg != 16'hffff) begin
      period_cnt_reg <= period_cnt_reg + 16'h0001;
    end
  end

  // =========================================================
  // 24 ticks per measured symbol period, phase restarted by sync
  logic [15:0] tick_acc_reg;
  logic [16:0] tick_sum;

  assign tick_sum = {1'b0, tick_acc_reg} + {1'b0, OSR};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tick_acc_reg <= 16'h0000;
      mod_tick     <= 1'b0;
    end else if (sync_edge) begin
      // start one step in so the 24th tick lands before the next sync, not on it
      tick_acc_reg <= OSR;
      mod_tick     <= 1'b0;
    end else if (tick_sum >= {1'b0, period_reg}) begin
      tick_acc_reg <= 16'(tick_sum - {1'b0, period_reg});
      mod_tick     <= 1'b1;
    end else begin
      tick_acc_reg <= tick_sum[15:0];
      mod_tick     <= 1'b0;
    end
  end

  // =========================================================
  // static controls latched at the symbol boundary
  logic [1:0] gain_reg;
  logic       loop_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gain_reg <= 2'b00;
      loop_reg <= 1'b0;
    end else if (sym_edge) begin
      gain_reg <= {pin_reg[5], pin_reg[4]};
      loop_reg <= pin_reg[6];
    end
  end

  assign gain_code       = gain_reg;
  assign line_disconnect = loop_reg;

  // =========================================================
  // difference and gain stage
  function automatic logic [15:0] gain_of(input logic [1:0] code);
    case (code)
      2'b00:   gain_of = GAIN_0DB;
      2'b01:   gain_of = GAIN_3P25DB;
      2'b10:   gain_of = GAIN_6DB;
      default: gain_of = GAIN_9DB;
    endcase
  endfunction : gain_of

  logic signed [IN_W:0]   line_term;
  logic signed [IN_W:0]   diff;
  logic signed [33:0]     scaled;
  logic signed [WORD_W-1:0] sample;

  // line path opened in loopback, hybrid path always connected
  assign line_term = loop_reg ? '0 : (IN_W+1)'($signed(line_receive_input));
  // unity weight on both inputs, hybrid subtracted
  assign diff      = line_term - (IN_W+1)'($signed(hybrid_receive_input));
  assign scaled    = (34'(diff) * $signed({1'b0, gain_of(gain_reg)})) >>> (GAIN_FRAC + FS_SHIFT);

  always_comb begin
    if (scaled > 34'sd8191) begin
      sample = 14'sh1fff;
    end else if (scaled < -34'sd8192) begin
      sample = -14'sh2000;
    end else begin
      sample = scaled[WORD_W-1:0];
    end
  end

  // =========================================================
  // decimator: boxcar of 12 ticks, its null spacing follows the tick rate
  hafe_dec_state_t   dec_state_reg;
  logic [3:0]        dec_cnt_reg;
  logic signed [17:0] dec_sum_reg;
  logic signed [17:0] dec_sum_next;
  logic signed [34:0] avg_prod;
  logic signed [WORD_W-1:0] avg;
  logic              word_done;

  assign dec_sum_next = dec_sum_reg + 18'(sample);
  assign word_done    = mod_tick && (dec_cnt_reg == DECIM - 4'h1) && (dec_state_reg != HAFE_IDLE);
  assign avg_prod     = 35'(dec_sum_next) * $signed({1'b0, RECIP_12});

  // reciprocal of twelve rounds up, so a full-scale negative average would wrap
  always_comb begin
    if (avg_prod >= 35'sh10000000) begin
      avg = 14'sh1fff;
    end else if (avg_prod < -35'sh10000000) begin
      avg = 14'sh2000;
    end else begin
      avg = avg_prod[RECIP_FRAC + WORD_W - 1:RECIP_FRAC];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_state_reg <= HAFE_IDLE;
      dec_cnt_reg   <= 4'h0;
      dec_sum_reg   <= '0;
    end else if (sync_edge) begin
      dec_state_reg <= HAFE_WORD0;
      dec_cnt_reg   <= 4'h0;
      dec_sum_reg   <= '0;
    end else if (mod_tick && dec_state_reg != HAFE_IDLE) begin
      if (word_done) begin
        dec_cnt_reg <= 4'h0;
        dec_sum_reg <= '0;
        case (dec_state_reg)
          HAFE_WORD0: dec_state_reg <= HAFE_WORD1;
          HAFE_WORD1: dec_state_reg <= HAFE_WORD0;
          default:    dec_state_reg <= HAFE_IDLE;
        endcase
      end else begin
        dec_cnt_reg <= dec_cnt_reg + 4'h1;
        dec_sum_reg <= dec_sum_next;
      end
    end
  end

  // output word stands until the next word; the second of a symbol is held across sync
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      receive_word        <= '0;
      receive_word_phase  <= 1'b0;
      receive_word_strobe <= 1'b0;
    end else begin
      receive_word_strobe <= word_done;
      if (word_done) begin
        receive_word       <= {~avg[WORD_W-1], avg[WORD_W-2:0]};
        receive_word_phase <= (dec_state_reg == HAFE_WORD1);
      end
    end
  end

  // =========================================================
  // 2b1q former: sign from positive line, magnitude from negative line
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_level <= 3'b001;
    end else if (sym_edge) begin
      case ({pin_reg[1], pin_reg[2]})
        2'b10:   tx_level <= 3'b011;
        2'b11:   tx_level <= 3'b001;
        2'b01:   tx_level <= 3'b111;
        default: tx_level <= 3'b101;
      endcase
    end
  end

  // =========================================================
  // receive fifo; a sticky overflow flag is set when the stream finds it full
  logic          ctrl_en_reg;
  logic          flush_reg;
  logic          ovf_reg;
  logic          sync_seen_reg;
  logic          fifo_out_valid;
  logic          fifo_pop;
  logic [16:0]   fifo_out_data;
  logic [LW:0]   fifo_level;

  hafe_fifo #(
    .WIDTH (WORD_W + 3),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .flush     (flush_reg),
    .in_valid  (receive_word_strobe & ctrl_en_reg),
    .in_ready  (fifo_in_ready),
    .in_data   ({receive_word_phase, 2'b00, receive_word}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // =========================================================
  // avalon slave: one wait cycle, answer on the second
  logic       ack_reg;
  logic       ovf_set;
  logic       ovf_clr;
  logic [31:0] rd_next;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign fifo_pop = avs_read & ack_reg & (avs_address == ADDR_DATA) & fifo_out_valid;
  assign ovf_set  = receive_word_strobe & ctrl_en_reg & ~fifo_in_ready;
  assign ovf_clr  = avs_write & ack_reg & (avs_address == ADDR_STATUS) & avs_byteenable[0]
                    & avs_writedata[ST_OVF_BIT];

  always_comb begin
    rd_next = 32'h0000_0000;
    if (avs_address == ADDR_CTRL) begin
      rd_next[CTRL_EN_BIT] = ctrl_en_reg;
    end else if (avs_address == ADDR_STATUS) begin
      rd_next[ST_OVF_BIT]  = ovf_reg;
      rd_next[ST_SYNC_BIT] = sync_seen_reg;
      rd_next[ST_LOOP_BIT] = loop_reg;
      rd_next[ST_LEVEL_LSB +: LW+1] = fifo_level;
    end else if (avs_address == ADDR_DATA) begin
      rd_next[DATA_VALID_BIT] = fifo_out_valid;
      rd_next[DATA_PHASE_BIT:0] = fifo_out_valid ? fifo_out_data : 17'h00000;
    end else if (avs_address == ADDR_PERIOD) begin
      rd_next[15:0] = period_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        avs_readdata <= rd_next;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_en_reg <= CTRL_EN_RESET;
      flush_reg   <= 1'b0;
    end else begin
      flush_reg <= 1'b0;
      if (avs_write & ack_reg & (avs_address == ADDR_CTRL) & avs_byteenable[0]) begin
        ctrl_en_reg <= avs_writedata[CTRL_EN_BIT];
        flush_reg   <= avs_writedata[CTRL_FLUSH_BIT];
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ovf_reg       <= 1'b0;
      sync_seen_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_set | (ovf_reg & ~ovf_clr);
      if (sync_edge) begin
        sync_seen_reg <= 1'b1;
      end
    end
  end
endmodule : hafe_receive_interface

// ===== hafe_pkg.sv
// package for the line front end receive interface
// assumes a single 100 MHz ref_clk domain and a byte-addressed avalon slave
package hafe_pkg;
  // =========================================================
  // clock and symbol timing
  localparam int          REF_CLK_HZ      = 100_000_000;
  localparam int          SYM_RATE_HZ     = 1_168_000;
  localparam logic [15:0] PERIOD_RESET    = 16'(REF_CLK_HZ / SYM_RATE_HZ);
  localparam logic [15:0] OSR             = 16'h0018;
  localparam logic [3:0]  DECIM           = 4'hc;
  // =========================================================
  // data path
  localparam int          WORD_W          = 14;
  localparam int          IN_W            = 16;
  localparam int          GAIN_FRAC       = 12;
  localparam int          FS_SHIFT        = 3;
  localparam logic [15:0] GAIN_0DB        = 16'h1000;
  localparam logic [15:0] GAIN_3P25DB     = 16'h1742;
  localparam logic [15:0] GAIN_6DB        = 16'h1fed;
  localparam logic [15:0] GAIN_9DB        = 16'h2d18;
  localparam logic [15:0] RECIP_12        = 16'h0aab;
  localparam int          RECIP_FRAC      = 15;
  localparam int          FIFO_DEPTH      = 8;
  // =========================================================
  // register map (byte addresses)
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_DATA       = 4'h8;
  localparam logic [3:0]  ADDR_PERIOD     = 4'hc;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_FLUSH_BIT  = 1;
  localparam logic        CTRL_EN_RESET   = 1'b1;
  localparam int          ST_OVF_BIT      = 0;
  localparam int          ST_SYNC_BIT     = 1;
  localparam int          ST_LOOP_BIT     = 2;
  localparam int          ST_LEVEL_LSB    = 8;
  localparam int          DATA_VALID_BIT  = 31;
  localparam int          DATA_PHASE_BIT  = 16;
  // =========================================================
  // decimator state
  typedef enum logic [1:0] {
    HAFE_IDLE  = 2'b00,
    HAFE_WORD0 = 2'b01,
    HAFE_WORD1 = 2'b11
  } hafe_dec_state_t;
endpackage : hafe_pkg

// ===== hafe_rx_asserts.sv
// checker for the receive interface top ports
// assumes one ref_clk domain and the host model on the pins
`timescale 1ns/10ps
// =========================================================
// checker
module hafe_rx_asserts
  import hafe_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire logic              symbol_clock_in,
  input wire logic              symbol_data_pos,
  input wire logic              symbol_data_neg,
  input wire logic              receive_sync_pulse,
  input wire logic              gain_select_hi,
  input wire logic              gain_select_lo,
  input wire logic              loopback_ctrl,
  input wire logic [WORD_W-1:0] receive_word,
  input wire logic              receive_word_phase,
  input wire logic              receive_word_strobe,
  input wire logic [2:0]        tx_level,
  input wire logic              line_disconnect,
  input wire logic [1:0]        gain_code,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  function automatic logic [2:0] lvl(input logic p, input logic n);
    return p ? (n ? 3'h1 : 3'h3) : (n ? 3'h7 : 3'h5);
  endfunction : lvl
  sequence sym_rise_s; $rose(symbol_clock_in); endsequence
  sequence word0_s; receive_word_strobe && !receive_word_phase; endsequence
  sequence word1_s; receive_word_strobe && receive_word_phase; endsequence
  strobe_pulse_a: assert property (receive_word_strobe |=> !receive_word_strobe)
    else $error("word strobe wider than one cycle");
  sync_word0_a: assert property ($rose(receive_sync_pulse) |-> ##[40:90] word0_s)
    else $error("no first word after sync");
  word_pair_a: assert property (word0_s |-> ##[40:80] word1_s)
    else $error("second word of symbol missing");
  word_hold_a: assert property (!receive_word_strobe |-> $stable(receive_word))
    else $error("word changed without strobe");
  gain_latch_a: assert property (sym_rise_s |-> ##8 gain_code == {$past(gain_select_hi, 8), $past(gain_select_lo, 8)})
    else $error("gain code not taken at symbol rise");
  loop_latch_a: assert property (sym_rise_s |-> ##8 line_disconnect == $past(loopback_ctrl, 8))
    else $error("loopback not taken at symbol rise");
  level_map_a: assert property (sym_rise_s |-> ##8 tx_level == lvl($past(symbol_data_pos, 8), $past(symbol_data_neg, 8)))
    else $error("pulse level does not match symbol");
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait");
  write_wait_a: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write not answered after one wait");
endmodule : hafe_rx_asserts

bind hafe_receive_interface hafe_rx_asserts u_chk (.ref_clk, .srst, .symbol_clock_in, .symbol_data_pos,
  .symbol_data_neg, .receive_sync_pulse, .gain_select_hi, .gain_select_lo, .loopback_ctrl, .receive_word,
  .receive_word_phase, .receive_word_strobe, .tx_level, .line_disconnect, .gain_code, .avs_read, .avs_write,
  .avs_waitrequest);

// ===== hafe_host_model.sv
// host dsp model: symbol clock, sync pulse and 2b1q symbols
// assumes ref_clk is the time base; rate and lag change only at a symbol start
`timescale 1ns/10ps
// =========================================================
// host model
module hafe_host_model (
  input wire logic       ref_clk,
  input wire logic [3:0] sync_lag,
  input wire logic [7:0] sym_cyc,
  output logic           symbol_clock_in,
  output logic           symbol_data_pos,
  output logic           symbol_data_neg,
  output logic           receive_sync_pulse
);
  logic [7:0] cnt_reg = 8'h00;
  logic [7:0] per_reg = 8'h64;
  logic [7:0] off_reg = 8'h00;
  logic [1:0] sym_reg = 2'h0;
  always_ff @(posedge ref_clk) begin
    if (cnt_reg == per_reg - 8'h01) begin
      cnt_reg <= 8'h00;
      per_reg <= sym_cyc;
      off_reg <= 8'((12'(sync_lag) * 12'(sym_cyc)) >> 4);
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // symbols move mid-period so they are steady at the clock rise
  always_ff @(posedge ref_clk) begin
    if (cnt_reg == (per_reg >> 1)) begin
      sym_reg <= sym_reg + 2'h1;
    end
  end
  assign symbol_clock_in = cnt_reg < (per_reg >> 1);
  assign symbol_data_pos = sym_reg[1];
  assign symbol_data_neg = sym_reg[0];
  assign receive_sync_pulse = (cnt_reg >= off_reg) && (cnt_reg < off_reg + 8'h08);
endmodule : hafe_host_model

// ===== testbench.sv
// self-checking bench for the receive interface
// assumes the host model drives the symbol and sync pins; the bench owns avalon, gain and loopback pins and samples
`timescale 1ns/10ps
module testbench
  import hafe_pkg::*;
;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic gain_select_hi = 1'h0, gain_select_lo = 1'h0, loopback_ctrl = 1'h0;
  logic [IN_W-1:0] line_receive_input = 16'h0, hybrid_receive_input = 16'h0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, sync_lag = 4'h0;
  logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, wr_s;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_s, rdv;
  logic [7:0] sym_cyc = 8'h64;
  logic symbol_clock_in, symbol_data_pos, symbol_data_neg, receive_sync_pulse;
  logic [WORD_W-1:0] receive_word, last_word;
  logic receive_word_phase, receive_word_strobe, fifo_in_ready, line_disconnect, mod_tick;
  logic [1:0] gain_code;
  int miscompares = 0, total_checks = 0, n_strobe = 0, n_tick = 0, nv, ph;
  int tl [5] = '{32767, -32768, 4660, 16384, 16384};
  int th [5] = '{0, 0, 4660, -16384, -16384};
  int tg [5] = '{3, 3, 1, 0, 0};
  logic tlp [5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
  always #5 ref_clk = ~ref_clk;
  hafe_host_model u_host (.ref_clk, .sync_lag, .sym_cyc, .symbol_clock_in, .symbol_data_pos, .symbol_data_neg,
    .receive_sync_pulse);
  hafe_receive_interface #(.FIFO_DEPTH_P(FIFO_DEPTH)) u_dut (.ref_clk, .srst, .symbol_clock_in, .symbol_data_pos,
    .symbol_data_neg, .receive_sync_pulse, .gain_select_hi, .gain_select_lo, .loopback_ctrl, .line_receive_input,
    .hybrid_receive_input, .receive_word, .receive_word_phase, .receive_word_strobe, .fifo_in_ready, .tx_level(),
    .line_disconnect, .gain_code, .mod_tick, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);
  // =========================================================
  // monitor: sampled mid-cycle, where registered outputs are settled
  always @(negedge ref_clk) begin
    wr_s = avs_waitrequest;
    rd_s = avs_readdata;
    if (receive_word_strobe === 1'h1) n_strobe++;
    if (mod_tick === 1'h1) n_tick++;
    if (receive_word_strobe === 1'h1 && receive_word_phase === 1'h0) last_word = receive_word;
  end
  // =========================================================
  // tasks
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_cyc
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do begin
      @(posedge ref_clk);
    end while (wr_s !== 1'h0);
    d = rd_s;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    bus(1'h0, a, 32'h0, d);
  endtask : reg_rd
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'h1, a, wd, dummy);
  endtask : reg_wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_near(input logic [31:0] got, input int exp, input int tol);
    total_checks++;
    if ($isunknown(got) || int'(got) - exp > tol || exp - int'(got) > tol) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_near
  // offset binary word from the difference, gain and clamp; small slack for averaging
  function automatic int exp_word(input int ln, input int hy, input int g, input logic lp);
    int d;
    d = ((lp ? 0 : ln) - hy) * int'(g == 0 ? GAIN_0DB : g == 1 ? GAIN_3P25DB : g == 2 ? GAIN_6DB : GAIN_9DB);
    d = d >>> 15;
    d = d > 8191 ? 8191 : (d < -8192 ? -8192 : d);
    return d + 8192;
  endfunction : exp_word
  // pins change while the symbol clock is low, well away from its rise
  task automatic set_rx(input int ln, input int hy, input int g, input logic lp);
    @(negedge symbol_clock_in);
    line_receive_input <= 16'(ln);
    hybrid_receive_input <= 16'(hy);
    gain_select_hi <= g[1];
    gain_select_lo <= g[0];
    loopback_ctrl <= lp;
    wait_cyc(600);
  endtask : set_rx
  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // =========================================================
  // tests
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'h0;
    reg_rd(ADDR_CTRL, rdv);
    chk(rdv, 32'h1);
    reg_rd(4'h2, rdv);
    chk(rdv, 32'h0);
    set_rx(16384, 0, 0, 1'h0);
    for (int k = 0; k < 16; k++) begin
      sync_lag <= 4'(k);
      wait_cyc(300);
      n_strobe = 0;
      n_tick = 0;
      wait_cyc(200);
      chk(32'(n_strobe), 32'h4);
      chk_near(32'(n_tick), 48, 2);
      chk_near(32'(last_word), exp_word(16384, 0, 0, 1'h0), 2);
    end
    reg_rd(ADDR_PERIOD, rdv);
    chk(rdv, 32'h64);
    for (int g = 0; g < 4; g++) begin
      set_rx(16384, 0, g, 1'h0);
      chk(32'(gain_code), 32'(g));
      chk_near(32'(last_word), exp_word(16384, 0, g, 1'h0), 2);
    end
    for (int i = 0; i < 5; i++) begin
      set_rx(tl[i], th[i], tg[i], tlp[i]);
      chk(32'(line_disconnect), 32'(tlp[i]));
      chk_near(32'(last_word), exp_word(tl[i], th[i], tg[i], tlp[i]), 2);
    end
    // fill past full with no reader, then drain with the fill stopped
    reg_wr(ADDR_CTRL, 32'h3);
    wait_cyc(600);
    reg_rd(ADDR_STATUS, rdv);
    chk(32'(rdv[11:0]), 32'h803);
    chk(32'(fifo_in_ready), 32'h0);
    reg_wr(ADDR_CTRL, 32'h0);
    nv = 0;
    ph = 2;
    for (int i = 0; i < 10; i++) begin
      reg_rd(ADDR_DATA, rdv);
      if (rdv[DATA_VALID_BIT] === 1'h1) begin
        nv++;
        chk_near(32'(rdv[13:0]), exp_word(16384, -16384, 0, 1'h0), 2);
        if (ph != 2) chk(32'(rdv[DATA_PHASE_BIT]), 32'(ph ^ 1));
        ph = int'(rdv[DATA_PHASE_BIT]);
      end
    end
    chk(32'(nv), 32'h8);
    chk(32'(fifo_in_ready), 32'h1);
    reg_wr(ADDR_STATUS, 32'h1);
    reg_rd(ADDR_STATUS, rdv);
    chk(32'({rdv[11:8], rdv[0]}), 32'h0);
    // slower symbol clock: timing and word rate follow it
    sym_cyc <= 8'h82;
    wait_cyc(800);
    reg_rd(ADDR_PERIOD, rdv);
    chk(rdv, 32'h82);
    n_strobe = 0;
    wait_cyc(260);
    chk(32'(n_strobe), 32'h4);
    chk_near(32'(last_word), exp_word(16384, -16384, 0, 1'h0), 2);
    end_sim();
  end
endmodule : testbench
